// ===== pkg/scr_pkg.sv
// constants shared by the standard serial configuration register group
package scr_pkg;
  // byte addresses
  localparam logic [14:0] SCR_ADDR_SERIAL_CFG = 15'h0000;
  localparam logic [14:0] SCR_ADDR_OPER_CFG   = 15'h0002;
  localparam logic [14:0] SCR_ADDR_CLASS      = 15'h0003;
  localparam logic [14:0] SCR_ADDR_FAMILY_LO  = 15'h0004;
  localparam logic [14:0] SCR_ADDR_FAMILY_HI  = 15'h0005;
  localparam logic [14:0] SCR_ADDR_REVISION   = 15'h0006;
  // field positions
  localparam int SCR_BIT_FULL_RESET = 7;
  localparam int SCR_BIT_STREAM_DIR = 5;
  localparam int SCR_BIT_FOUR_WIRE  = 4;
  // reset values
  localparam logic       SCR_RST_STREAM_DIR = 1'b1;
  localparam logic [1:0] SCR_RST_MODE       = 2'h0;
  // fixed read-back of the four-wire indicator
  localparam logic       SCR_FOUR_WIRE_VAL  = 1'b1;
  // identification codes; the values are arbitrary
  localparam logic [3:0]  SCR_CLASS_CODE    = 4'h9;
  localparam logic [15:0] SCR_FAMILY_CODE   = 16'h5A5A;
  localparam logic [7:0]  SCR_REVISION_CODE = 8'hC3;
  // timing: recovery after a full reset, in ns
  localparam int SCR_RECOVERY_NS    = 750;
  localparam int SCR_CLK_PERIOD_NS  = 20;
  localparam int SCR_RECOVERY_CYC   = (SCR_RECOVERY_NS + SCR_CLK_PERIOD_NS - 1) / SCR_CLK_PERIOD_NS;
  // serial frame: one r/w bit, 15 address bits, then data bytes
  localparam int SCR_ADDR_W = 15;
endpackage : scr_pkg

// ===== sim/scr_host.sv
// host controller model driving the four-wire serial pins
`timescale 1ns/100ps
module scr_host (
  // clock
  input wire logic clock,
  // serial pins
  output logic     sclk,
  output logic     cs_n,
  output logic     sdi,
  input wire logic sdo
);
  // slow sclk: twice the pin synchroniser latency per half period
  localparam int half = 8;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // data set while sclk low, sdo taken at the rise
  task automatic bit_io(input logic b, output logic s);
    sdi = b;
    repeat (half) @(posedge clock);
    #1 sclk = 1'b1;
    s = sdo;
    repeat (half) @(posedge clock);
    #1 sclk = 1'b0;
  endtask : bit_io
  // one frame: header, then nb bytes msb first
  task automatic xfer(input logic is_rd, input logic [14:0] a, input logic [15:0] wdat,
                      input int nb, output logic [15:0] rdat);
    logic s;
    rdat = 16'h0000;
    @(posedge clock);
    #1 cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) bit_io(i == 15 ? is_rd : a[i], s);
    for (int i = 0; i < nb * 8; i++) begin
      bit_io(is_rd ? ~sdi : wdat[15 - i], s);
      rdat = {rdat[14:0], s};
    end
    repeat (half) @(posedge clock);
    #1 cs_n = 1'b1;
    sdi = ~sdi;
    repeat (half) @(posedge clock);
  endtask : xfer
endmodule : scr_host

// ===== sim/scr_regs_assertions.sv
// port assertions for the configuration register group
`timescale 1ns/100ps
module scr_regs_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  // device state
  input wire logic power_down,
  input wire logic device_reset,
  input wire logic busy
);
  import scr_pkg::*;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  //////////////////////////////////////////////////////////////////////
  // busy cycles since the last pulse; saturates so it never wraps
  always_comb begin
    cnt_next = cnt_reg;
    if (device_reset) cnt_next = 8'h00;
    else if (busy && cnt_reg != 8'hFF) cnt_next = cnt_reg + 8'h01;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) cnt_reg <= 8'h00;
    else cnt_reg <= cnt_next;
  end
  //////////////////////////////////////////////////////////////////////
  a_pulse_busy: assert property (device_reset |=> busy [*8])
    else $error("busy missing after reset pulse");
  a_pulse_once: assert property (device_reset |=> !device_reset)
    else $error("reset pulse longer than one cycle");
  a_busy_len: assert property ($fell(busy) |-> cnt_reg == SCR_RECOVERY_CYC)
    else $error("recovery span wrong");
  a_busy_cause: assert property ($rose(busy) |-> $past(device_reset))
    else $error("busy without reset pulse");
  a_reset_mode: assert property (device_reset |-> ##[1:2] !power_down)
    else $error("power down survives full reset");
  a_oe_idle: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("sdo driven outside frame");
  a_sdo_hold: assert property (sdo_oe && $changed(sdo) |-> !sclk)
    else $error("sdo moved while sclk high");
  a_pd_frame: assert property ($changed(power_down) |-> !cs_n)
    else $error("power down moved outside frame");
endmodule : scr_regs_assertions

// ===== sim/test_scr_regs.sv
// self-checking bench for the configuration register group
`timescale 1ns/100ps
module test_scr_regs;
  import scr_pkg::*;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        sclk, cs_n, sdi, sdo, sdo_oe, power_down, device_reset, busy;
  logic [15:0] rv;
  logic        sdo_pin;
  int          n_oe = 0;
  int          oe_mark = 0;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          n_pulse = 0;
  always #10 clock = ~clock;
  scr_regs u_scr_regs (.clock(clock), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .power_down(power_down),
    .device_reset(device_reset), .busy(busy));
  // a released line shows the inverse, so a sample taken while undriven shows up
  assign sdo_pin = sdo_oe ? sdo : ~sdo;
  scr_host u_scr_host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_pin));
  always @(posedge clock) if (device_reset === 1'b1) n_pulse++;
  always @(posedge clock) if (sdo_oe === 1'b1) n_oe++;
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    u_scr_host.xfer(1'b0, a, {d, 8'h00}, 1, rv);
  endtask : wr
  task automatic rd(input string nm, input logic [14:0] a, input int nb,
                    input logic [15:0] exp);
    u_scr_host.xfer(1'b1, a, 16'h0000, nb, rv);
    chk(nm, rv, exp);
  endtask : rd
  task automatic summarize;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (6) @(posedge clock);
    // reset values and fixed codes
    rd("serial", SCR_ADDR_SERIAL_CFG, 1, 16'h0030);
    chk("oe_read", {15'h0000, n_oe != 0}, 16'h0001);
    rd("oper", SCR_ADDR_OPER_CFG, 1, 16'h0000);
    rd("class", SCR_ADDR_CLASS, 1, {12'h000, SCR_CLASS_CODE});
    rd("fam_up", SCR_ADDR_FAMILY_LO, 2, {SCR_FAMILY_CODE[7:0], SCR_FAMILY_CODE[15:8]});
    rd("rev", SCR_ADDR_REVISION, 1, {8'h00, SCR_REVISION_CODE});
    rd("unmapped", 15'h0001, 1, 16'h0000);
    // fixed codes ignore writes; no drive on sdo during writes
    oe_mark = n_oe;
    wr(SCR_ADDR_CLASS, 8'hFF);
    wr(SCR_ADDR_REVISION, 8'h00);
    chk("oe_write", n_oe[15:0], oe_mark[15:0]);
    rd("class_wr", SCR_ADDR_CLASS, 1, {12'h000, SCR_CLASS_CODE});
    rd("rev_wr", SCR_ADDR_REVISION, 1, {8'h00, SCR_REVISION_CODE});
    // descending stream; reserved and fixed bits keep their value
    wr(SCR_ADDR_SERIAL_CFG, 8'h4F);
    rd("serial_wr", SCR_ADDR_SERIAL_CFG, 1, 16'h0010);
    rd("fam_down", SCR_ADDR_FAMILY_HI, 2, SCR_FAMILY_CODE);
    // every mode code, power down left set by the last one
    for (int m = 0; m < 4; m++) begin
      wr(SCR_ADDR_OPER_CFG, {6'h3F, m[1:0]});
      chk("power_down", {15'h0000, power_down}, {15'h0000, m[1]});
      rd("mode", SCR_ADDR_OPER_CFG, 1, {14'h0000, m[1:0]});
    end
    // full reset from power down with descending stream set
    wr(SCR_ADDR_SERIAL_CFG, 8'h80);
    chk("busy", {15'h0000, busy}, 16'h0001);
    // quiet through the recovery span
    repeat (SCR_RECOVERY_CYC) @(posedge clock);
    chk("pulses", n_pulse[15:0], 16'h0001);
    chk("pd_after", {15'h0000, power_down}, 16'h0000);
    rd("serial_rst", SCR_ADDR_SERIAL_CFG, 1, 16'h0030);
    rd("oper_rst", SCR_ADDR_OPER_CFG, 1, 16'h0000);
    rd("fam_rst", SCR_ADDR_FAMILY_LO, 2, {SCR_FAMILY_CODE[7:0], SCR_FAMILY_CODE[15:8]});
    // async reset in mid-run brings back mode and stream direction
    wr(SCR_ADDR_OPER_CFG, 8'h02);
    wr(SCR_ADDR_SERIAL_CFG, 8'h00);
    chk("pd_set", {15'h0000, power_down}, 16'h0001);
    #1 arst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (6) @(posedge clock);
    chk("pd_arst", {15'h0000, power_down}, 16'h0000);
    rd("serial_arst", SCR_ADDR_SERIAL_CFG, 1, 16'h0030);
    rd("oper_arst", SCR_ADDR_OPER_CFG, 1, 16'h0000);
    summarize();
  end
  // watchdog well beyond the roughly 12k cycles the tests need
  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    summarize();
  end
endmodule : test_scr_regs

bind scr_regs scr_regs_assertions u_scr_regs_assertions (.clock(clock), .arst_n(arst_n),
  .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
  .power_down(power_down), .device_reset(device_reset), .busy(busy));

// ===== verilog/scr_regs.sv
// four-wire serial slave with the standard configuration register group
`timescale 1ns/100ps
// Overview of operation
// RULE1: writing one to bit 7 of serial config resets all device logic.
// RULE2: the full-reset trigger bit clears itself after the reset.
// RULE3: host issues no transaction for 750 ns after triggering reset.
// RULE4: bit 5 picks address step while streaming; one ascends, reset one.
// RULE5: bit 4 is read-only and always reads one, four-wire mode.
// RULE6: mode field bits 1-0 resets to 00; values 0 and 1 mean normal.
// RULE7: mode values 2 and 3 power the whole device down.
// RULE8: no low-power functional or fast-resume modes; only normal or down.
// RULE9: class register holds a read-only 4-bit code, upper nibble reserved.
// RULE10: read-only 16-bit family code across two byte addresses.
// RULE11: read-only 8-bit revision code at byte address 0x006.
// RULE12: writes to read-only or reserved bits do nothing; reserved reads zero.
module scr_regs (
  // clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // serial pins
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdi,
  output logic      sdo,
  output logic      sdo_oe,
  // device state
  output logic      power_down,
  output logic      device_reset,
  output logic      busy
);
  import scr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;

  scr_sync u_sync_sclk (
    .clock    (clock),
    .arst_n   (arst_n),
    .rst_val  (1'b0),
    .pin_in   (sclk),
    .level_out(sclk_s)
  );
  scr_sync u_sync_cs (
    .clock    (clock),
    .arst_n   (arst_n),
    .rst_val  (1'b1),
    .pin_in   (cs_n),
    .level_out(cs_n_s)
  );
  scr_sync u_sync_sdi (
    .clock    (clock),
    .arst_n   (arst_n),
    .rst_val  (1'b0),
    .pin_in   (sdi),
    .level_out(sdi_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [2:0] {
    SCR_ST_IDLE = 3'b001,
    SCR_ST_HDR  = 3'b010,
    SCR_ST_DATA = 3'b100
  } scr_state_e;

  localparam int RCW = $clog2(SCR_RECOVERY_CYC + 1);

  typedef struct packed {
    scr_state_e           state;
    logic                 sclk_d;
    logic                 cs_d;
    logic                 rd;
    logic [SCR_ADDR_W-1:0] addr;
    logic [4:0]           cnt;
    logic [7:0]           shift;
    logic [7:0]           tx;
    logic                 sdo;
    logic                 stream_dir;
    logic                 reset_trig;
    logic [1:0]           mode;
    logic [RCW-1:0]       recov;
  } scr_regs_s;

  scr_regs_s st_reg;
  scr_regs_s st_next;

  ////////////////////////////////////////////////////////////////////////////
  // register read decode
  function automatic logic [7:0] scr_read(input logic [SCR_ADDR_W-1:0] a,
                                          input logic dir, input logic [1:0] md);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      // RULE5: fixed four-wire bit
      SCR_ADDR_SERIAL_CFG: begin
        v[SCR_BIT_STREAM_DIR] = dir;
        v[SCR_BIT_FOUR_WIRE]  = SCR_FOUR_WIRE_VAL;
      end
      SCR_ADDR_OPER_CFG:  v[1:0] = md;
      // RULE9: class nibble only
      SCR_ADDR_CLASS:     v[3:0] = SCR_CLASS_CODE;
      // RULE10: family code halves
      SCR_ADDR_FAMILY_LO: v = SCR_FAMILY_CODE[7:0];
      SCR_ADDR_FAMILY_HI: v = SCR_FAMILY_CODE[15:8];
      // RULE11: revision code
      SCR_ADDR_REVISION:  v = SCR_REVISION_CODE;
      // RULE12: everything else reads zero
      default:            v = 8'h00;
    endcase
    return v;
  endfunction : scr_read

  // streaming address step
  function automatic logic [SCR_ADDR_W-1:0] scr_step(input logic [SCR_ADDR_W-1:0] a,
                                                     input logic dir);
    // RULE4: ascend on one, descend on zero
    return dir ? SCR_ADDR_W'(a + 1'b1) : SCR_ADDR_W'(a - 1'b1);
  endfunction : scr_step

  ////////////////////////////////////////////////////////////////////////////
  // next state
  logic rise;
  logic fall;
  logic [7:0] byte_in;

  always_comb begin
    st_next        = st_reg;
    rise           = sclk_s && !st_reg.sclk_d;
    fall           = !sclk_s && st_reg.sclk_d;
    byte_in        = {st_reg.shift[6:0], sdi_s};
    st_next.sclk_d = sclk_s;
    st_next.cs_d   = cs_n_s;
    // RULE3: hold off while the reset recovers; host must stay quiet
    if (st_reg.recov != '0) begin
      st_next.recov = RCW'(st_reg.recov - 1'b1);
      st_next.state = SCR_ST_IDLE;
    end else if (st_reg.reset_trig) begin
      // RULE1: full reset of all logic state
      st_next            = '0;
      st_next.state      = SCR_ST_IDLE;
      st_next.sclk_d     = sclk_s;
      st_next.cs_d       = cs_n_s;
      st_next.stream_dir = SCR_RST_STREAM_DIR;
      st_next.mode       = SCR_RST_MODE;
      // RULE2: trigger clears itself
      st_next.reset_trig = 1'b0;
      st_next.recov      = RCW'(SCR_RECOVERY_CYC);
    end else if (cs_n_s) begin
      st_next.state = SCR_ST_IDLE;
      st_next.cnt   = '0;
    end else begin
      case (st_reg.state)
        SCR_ST_IDLE: begin
          // start only on a select edge, so a frame cut by a full reset stays dropped
          if (st_reg.cs_d) begin
            st_next.state = SCR_ST_HDR;
            st_next.cnt   = '0;
          end
        end
        SCR_ST_HDR: begin
          if (rise) begin
            st_next.cnt = 5'(st_reg.cnt + 1'b1);
            if (st_reg.cnt == 5'h00) begin
              st_next.rd = sdi_s;
            end else begin
              st_next.addr = {st_reg.addr[SCR_ADDR_W-2:0], sdi_s};
            end
            if (st_reg.cnt == 5'h0F) begin
              st_next.state = SCR_ST_DATA;
              st_next.cnt   = '0;
              st_next.tx    = scr_read({st_reg.addr[SCR_ADDR_W-2:0], sdi_s},
                                       st_reg.stream_dir, st_reg.mode);
            end
          end
        end
        SCR_ST_DATA: begin
          // shift out on falling edge, sample on rising edge
          if (fall) begin
            st_next.sdo = st_reg.tx[7];
            st_next.tx  = {st_reg.tx[6:0], 1'b0};
          end
          if (rise) begin
            st_next.shift = byte_in;
            st_next.cnt   = 5'(st_reg.cnt + 1'b1);
            if (st_reg.cnt == 5'h07) begin
              st_next.cnt = '0;
              if (!st_reg.rd) begin
                // RULE12: only writable bits take the write
                case (st_reg.addr)
                  SCR_ADDR_SERIAL_CFG: begin
                    st_next.reset_trig = byte_in[SCR_BIT_FULL_RESET];
                    st_next.stream_dir = byte_in[SCR_BIT_STREAM_DIR];
                  end
                  // RULE6: mode field write
                  SCR_ADDR_OPER_CFG: st_next.mode = byte_in[1:0];
                  default: ;
                endcase
              end
              st_next.addr = scr_step(st_reg.addr, st_reg.stream_dir);
              st_next.tx   = scr_read(scr_step(st_reg.addr, st_reg.stream_dir),
                                      st_reg.stream_dir, st_reg.mode);
            end
          end
        end
        default: st_next.state = SCR_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg            <= '0;
      st_reg.state      <= SCR_ST_IDLE;
      st_reg.sclk_d     <= 1'b0;
      st_reg.cs_d       <= 1'b1;
      st_reg.stream_dir <= SCR_RST_STREAM_DIR;
      st_reg.mode       <= SCR_RST_MODE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign sdo          = st_reg.sdo;
  // drive only during the data phase of a read
  assign sdo_oe       = (st_reg.state == SCR_ST_DATA) && st_reg.rd && !cs_n_s;
  // RULE7: modes two and three power down; RULE8: no other low-power state
  assign power_down   = st_reg.mode[1];
  assign device_reset = st_reg.reset_trig;
  assign busy         = (st_reg.recov != '0);
endmodule : scr_regs

// ===== verilog/scr_sync.sv
// three-stage synchroniser for pin inputs, output changes when stages two and three agree
`timescale 1ns/100ps
module scr_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic rst_val,
  // pin side
  input  wire logic pin_in,
  // clean level
  output logic      level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } scr_sync_s;
  scr_sync_s st_reg;
  scr_sync_s st_next;

  // filter: the first stage feeds only the second
  always_comb begin
    st_next     = st_reg;
    // idle level folded in by inversion, so the reset value stays a constant
    st_next.s1  = pin_in ^ rst_val;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
    end
  end

  // reset values are constants only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // idle-high pins read their idle level straight out of reset, no false edge
  assign level_out = st_reg.lvl ^ rst_val;
endmodule : scr_sync
